// [logic/ide_busmaster_dma_ctrl_status.v]
// What this block does
// - Run bit rising edge alone starts DMA.
// - Data moves only while run set; stop final.
// - Hardware never clears the run bit.
// - Stop while active, no interrupt: abort, drop.
// - Direction bit: 0 to drive, 1 to memory.
// - Command register: run bit0, direction bit3.
// - Status: timeout, interrupt, fault, active bits.
// - Status flags bits 3..1 clear on one.
// - Registers at offsets 0h, 2h, 4h, 8h.
// - Active sets on start, clears on end/stop.
// - Interrupt flag sets on edge or completion.
// - Fault flag sets only on buffer overflow.
// - Timeout flag sets when ready-wait timer expires.
`timescale 1ns/100ps
`include "ide_dma_consts.vh"

module ide_busmaster_dma_ctrl_status (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire drive_irq_in,
  input wire drive_ready_in,
  input wire [`DATA_W-1:0] drv_rx_data_in,
  input wire drv_rx_valid_in,
  output wire drv_rx_ready_out,
  input wire [`DATA_W-1:0] mem_rd_data_in,
  input wire mem_rd_valid_in,
  output wire mem_rd_ready_out,
  input wire last_word_in,
  output wire [`DATA_W-1:0] mem_wr_data_out,
  output wire mem_wr_valid_out,
  input wire mem_wr_ready_in,
  output wire [`DATA_W-1:0] drv_tx_data_out,
  output wire drv_tx_valid_out,
  input wire drv_tx_ready_in,
  output wire run_out,
  output wire dir_out,
  output wire active_out,
  output wire [31:0] desc_ptr_out
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  reg run;
  reg dir;
  reg active;
  reg flt_flag;
  reg irq_flag;
  reg tmo_flag;
  reg [29:0] ptr_hi;
  reg tmr_en;
  reg [15:0] tmr_lim;
  reg [15:0] tmr_cnt;
  reg [1:0] irq_sync;
  reg [1:0] rdy_sync;
  reg irq_prev;
  reg [`DATA_W-1:0] buf_data [0:`BUF_DEPTH-1];
  reg [`BUF_DEPTH-1:0] buf_last;
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;

  ////////////////////////////////////////////////////////////////////////
  // Register port decode.

  // Each access is decoded at its exact offset; other addresses read zero.
  wire wr_cmd = wr_in && (addr_in == `OFF_CMD);
  wire wr_stat = wr_in && (addr_in == `OFF_STAT);
  wire wr_ptr_reg = wr_in && (addr_in == `OFF_PTR);
  wire wr_tmr = wr_in && (addr_in == `OFF_TMR);

  // Start needs the run bit to go from zero to one.
  wire start_pulse = wr_cmd && wdata_in[`CMD_RUN] && !run;
  // Writing zero while running ends the transfer for good.
  wire stop_pulse = wr_cmd && !wdata_in[`CMD_RUN] && run;
  // A stop before the drive has finished is an abort.
  wire abort = stop_pulse && active && !irq_flag;

  // Write-one-to-clear requests for the status flags.
  wire clr_tmo = wr_stat && wdata_in[`ST_TMO];
  wire clr_irq = wr_stat && wdata_in[`ST_IRQ];
  wire clr_flt = wr_stat && wdata_in[`ST_FLT];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Two flops per pin; the edge detector reads only the second flop.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_sync <= 2'h0;
      rdy_sync <= 2'h3;
      irq_prev <= 1'b0;
    end else begin
      irq_sync <= {irq_sync[0], drive_irq_in};
      rdy_sync <= {rdy_sync[0], drive_ready_in};
      irq_prev <= irq_sync[1];
    end
  end

  wire irq_rise = irq_sync[1] && !irq_prev;
  wire drive_ready = rdy_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Buffer control.

  // Words move only while run is set and the channel is active.
  wire move_en = run && active;
  wire buf_full = (count == `CNT_FULL);
  wire buf_empty = (count == `CNT_EMPTY);

  // Direction picks the source and the sink of the buffer.
  wire src_valid = dir ? drv_rx_valid_in : mem_rd_valid_in;
  wire [`DATA_W-1:0] src_data = dir ? drv_rx_data_in : mem_rd_data_in;
  wire sink_ready = dir ? mem_wr_ready_in : drv_tx_ready_in;

  wire push = move_en && src_valid && !buf_full;
  wire out_valid = move_en && !buf_empty;
  wire pop = out_valid && sink_ready;
  // The word carrying the end-of-table mark completes the transfer.
  wire done = pop && buf_last[rd_ptr];
  // The drive side offering a word while the buffer is full raises the fault; the word waits.
  wire overflow = move_en && dir && drv_rx_valid_in && buf_full;
  // Start and stop both discard what the buffer holds.
  wire flush = start_pulse || abort || stop_pulse;

  // Ready towards each source, gated by direction and space.
  assign drv_rx_ready_out = move_en && dir && !buf_full;
  assign mem_rd_ready_out = move_en && !dir && !buf_full;

  // Valid towards each sink; data come from the buffer flops.
  assign mem_wr_valid_out = out_valid && dir;
  assign drv_tx_valid_out = out_valid && !dir;
  assign mem_wr_data_out = buf_data[rd_ptr];
  assign drv_tx_data_out = buf_data[rd_ptr];

  // Each buffer entry loads when the write pointer selects it.
  genvar gi;
  generate
    for (gi = 0; gi < `BUF_DEPTH; gi = gi + 1) begin : g_entry
      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          buf_data[gi] <= {`DATA_W{1'b0}};
          buf_last[gi] <= 1'b0;
        end else if (push && (wr_ptr == (gi == 1))) begin
          buf_data[gi] <= src_data;
          buf_last[gi] <= last_word_in;
        end
      end
    end
  endgenerate

  // Pointers and fill count; a flush wins over any move.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= `CNT_EMPTY;
    end else if (flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= `CNT_EMPTY;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command and pointer registers.

  // Run and direction follow software writes only.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run <= `CMD_RST;
      dir <= `CMD_RST;
    end else if (wr_cmd) begin
      run <= wdata_in[`CMD_RUN];
      dir <= wdata_in[`CMD_DIR];
    end
  end

  // Pointer keeps its two low bits at zero for word alignment.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ptr_hi <= `PTR_RST;
    end else if (wr_ptr_reg) begin
      ptr_hi <= wdata_in[31:2];
    end
  end

  // Ready-wait timer enable and limit.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmr_en <= 1'b0;
      tmr_lim <= `TMR_LIM_RST;
    end else if (wr_tmr) begin
      tmr_en <= wdata_in[`TMR_EN];
      tmr_lim <= wdata_in[`TMR_LIM_MSB:`TMR_LIM_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel activity and status flags.

  // Active sets on a start, clears on a stop or on completion.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active <= `FLAG_RST;
    end else if (start_pulse) begin
      active <= 1'b1;
    end else if (stop_pulse || done) begin
      active <= 1'b0;
    end
  end

  // Timer counts while the drive holds ready low during a transfer.
  wire tmr_run = tmr_en && active && !drive_ready;
  wire tmr_hit = tmr_run && (tmr_cnt == tmr_lim);

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmr_cnt <= 16'h0000;
    end else if (!tmr_run) begin
      tmr_cnt <= 16'h0000;
    end else if (!tmr_hit) begin
      tmr_cnt <= tmr_cnt + 16'h0001;
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmo_flag <= `FLAG_RST;
      irq_flag <= `FLAG_RST;
      flt_flag <= `FLAG_RST;
    end else begin
      tmo_flag <= (tmo_flag && !clr_tmo) || tmr_hit;
      irq_flag <= (irq_flag && !clr_irq) || irq_rise || done;
      flt_flag <= (flt_flag && !clr_flt) || overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data.

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `OFF_CMD: begin
          rdata_out <= {28'h0000000, dir, 2'h0, run};
        end
        `OFF_STAT: begin
          rdata_out <= {28'h0000000, tmo_flag, irq_flag, flt_flag, active};
        end
        `OFF_PTR: begin
          rdata_out <= {ptr_hi, 2'h0};
        end
        `OFF_TMR: begin
          rdata_out <= {tmr_lim, 15'h0000, tmr_en};
        end
        default: begin
          rdata_out <= 32'h00000000;
        end
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the descriptor engine.

  // Plain copies of control state for the fetch logic outside.
  assign run_out = run;
  assign dir_out = dir;
  assign active_out = active;
  assign desc_ptr_out = {ptr_hi, 2'h0};

endmodule

// [logic/ide_dma_consts.vh]
`ifndef IDE_DMA_CONSTS_VH
`define IDE_DMA_CONSTS_VH

// Register offsets on the plain register port.
`define OFF_CMD 8'h00
`define OFF_STAT 8'h02
`define OFF_PTR 8'h04
`define OFF_TMR 8'h08

// Command register fields.
`define CMD_RUN 0
`define CMD_DIR 3

// Status register fields.
`define ST_ACT 0
`define ST_FLT 1
`define ST_IRQ 2
`define ST_TMO 3

// Ready-wait timer register fields.
`define TMR_EN 0
`define TMR_LIM_LSB 16
`define TMR_LIM_MSB 31

// Reset values.
`define CMD_RST 1'b0
`define FLAG_RST 1'b0
`define PTR_RST 30'h00000000
`define TMR_LIM_RST 16'h00FF

// Data path sizes.
`define DATA_W 16
`define BUF_DEPTH 2
`define CNT_FULL 2'h2
`define CNT_EMPTY 2'h0

`endif

// [bench/ide_dma_checker_assertions.sv]
`timescale 1ns/100ps
// Watches the register port and the data-path readies of the DMA block.
module ide_dma_checker (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic drv_rx_ready_out,
  input wire logic mem_rd_ready_out,
  input wire logic run_out,
  input wire logic dir_out,
  input wire logic active_out
);
  // A write to the command register.
  wire cmd_wr = wr_in && addr_in == 8'h00;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  chk_run_stays: assert property (run_out && !(cmd_wr && !wdata_in[0]) |=> run_out)
    else $error("run dropped");
  chk_start_act: assert property (cmd_wr && wdata_in[0] && !run_out |=> active_out && run_out)
    else $error("no start");
  chk_no_restart: assert property (cmd_wr && wdata_in[0] && run_out && !active_out |=> !active_out)
    else $error("restart");
  chk_stop_clears: assert property (cmd_wr && !wdata_in[0] |=> !run_out && !active_out)
    else $error("stop ignored");
  chk_move_run: assert property (drv_rx_ready_out || mem_rd_ready_out |-> run_out && active_out)
    else $error("moves idle");
  chk_dir_sel: assert property (drv_rx_ready_out |-> dir_out && !mem_rd_ready_out)
    else $error("wrong way");
  chk_dir_reg: assert property (cmd_wr |=> dir_out == $past(wdata_in[3]))
    else $error("dir bit");
  chk_rd_status: assert property (rd_in && addr_in == 8'h02 |=> rdata_out[31:4] == 28'h0
    && rdata_out[0] == $past(active_out)) else $error("status read");
  cover property (cmd_wr && wdata_in[0] && !run_out);
  cover property (cmd_wr && !wdata_in[0] && active_out);
  cover property (active_out ##1 !active_out && run_out);
endmodule
bind ide_busmaster_dma_ctrl_status ide_dma_checker u_ide_dma_checker (.clk_sys_in, .arst_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .drv_rx_ready_out, .mem_rd_ready_out, .run_out, .dir_out, .active_out);

// [bench/ata_drive_model.sv]
`timescale 1ns/100ps
// Drive model: offers three words when asked, sinks words on alternate cycles.
module ata_drive_model (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire offer_in,
  input wire [15:0] tx_data_in,
  input wire tx_valid_in,
  output wire tx_ready_out,
  input wire rx_ready_in,
  output wire [15:0] rx_data_out,
  output wire rx_valid_out,
  output wire last_out,
  output reg [15:0] got_out,
  output reg [15:0] ntx_out
);
  reg [15:0] cnt;
  reg ph;
  // A released bus shows the inverse of the word, never a stale copy.
  assign rx_valid_out = offer_in && cnt < 16'h0003;
  assign rx_data_out = rx_valid_out ? cnt : ~cnt;
  assign last_out = cnt == 16'h0002;
  assign tx_ready_out = ph;
  // Counts words both ways through the drive's data port.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 16'h0000;
      ph <= 1'b0;
      got_out <= 16'h0000;
      ntx_out <= 16'h0000;
    end else begin
      ph <= ~ph;
      if (!offer_in)
        cnt <= 16'h0000;
      else if (rx_valid_out && rx_ready_in)
        cnt <= cnt + 16'h0001;
      if (tx_valid_in && tx_ready_out) begin
        got_out <= tx_data_in;
        ntx_out <= ntx_out + 16'h0001;
      end
    end
  end
endmodule

// [bench/ide_busmaster_dma_ctrl_status_tb.sv]
`timescale 1ns/100ps
module ide_busmaster_dma_ctrl_status_tb;
  logic clk_sys_in = 0, arst_n_in = 0, wr_in = 0, rd_in = 0, drive_irq_in = 0, drive_ready_in = 1;
  logic mem_go = 0, mem_wr_ready_in = 0, offer = 0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic [15:0] mcnt = 16'h0;
  wire [31:0] rdata_out, desc_ptr_out;
  wire [15:0] drv_rx_data_in, mem_wr_data_out, drv_tx_data_out, got, ntx;
  wire drv_rx_valid_in, drv_rx_ready_out, mem_rd_ready_out, mem_wr_valid_out, drv_tx_valid_out;
  wire drv_tx_ready_in, run_out, dir_out, active_out, p_last;
  wire mem_rd_valid_in = mem_go && mcnt < 16'h3;
  wire [15:0] mem_rd_data_in = mem_rd_valid_in ? mcnt : ~mcnt;
  wire last_word_in = dir_out ? p_last : mcnt == 16'h2;
  integer errors = 0, n_compared = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  // Memory source steps to the next word on each accepted push.
  always @(posedge clk_sys_in) mcnt <= !mem_go ? 16'h0 : mcnt + (mem_rd_valid_in && mem_rd_ready_out);
  ide_busmaster_dma_ctrl_status u_ide_busmaster_dma_ctrl_status (.clk_sys_in, .arst_n_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .drive_irq_in, .drive_ready_in, .drv_rx_data_in, .drv_rx_valid_in,
    .drv_rx_ready_out, .mem_rd_data_in, .mem_rd_valid_in, .mem_rd_ready_out, .last_word_in, .mem_wr_data_out,
    .mem_wr_valid_out, .mem_wr_ready_in, .drv_tx_data_out, .drv_tx_valid_out, .drv_tx_ready_in, .run_out,
    .dir_out, .active_out, .desc_ptr_out);
  ata_drive_model u_ata_drive_model (.clk_sys_in, .arst_n_in, .offer_in(offer), .tx_data_in(drv_tx_data_out),
    .tx_valid_in(drv_tx_valid_out), .tx_ready_out(drv_tx_ready_in), .rx_ready_in(drv_rx_ready_out),
    .rx_data_out(drv_rx_data_in), .rx_valid_out(drv_rx_valid_in), .last_out(p_last), .got_out(got), .ntx_out(ntx));
  // Compares and counts.
  task chk(input [31:0] g, input [31:0] e, input [8*6:1] nm);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e, "rdata");
    end
  endtask
  task t_regs;
    begin
      rd(8'h00, 32'h0);
      rd(8'h02, 32'h0);
      wr(8'h04, 32'hFFFFFFFF);
      #1 chk(desc_ptr_out, 32'hFFFFFFFC, "ptr");
      rd(8'h04, 32'hFFFFFFFC);
      rd(8'h06, 32'h0);
      wr(8'h00, 32'h0000FFFE);
      rd(8'h00, 32'h8);
    end
  endtask
  task t_to_mem;
    integer k;
    begin
      k = 0;
      wr(8'h00, 32'h9);
      offer <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      #1 chk(drv_rx_ready_out, 0, "rx_rdy");
      rd(8'h02, 32'h3);
      mem_wr_ready_in <= 1'b1;
      repeat (20) begin
        @(negedge clk_sys_in);
        if (mem_wr_valid_out && mem_wr_ready_in) begin
          chk(mem_wr_data_out, k, "word");
          k = k + 1;
        end
      end
      chk(k, 3, "count");
      rd(8'h02, 32'h6);
      rd(8'h00, 32'h9);
      wr(8'h00, 32'h9);
      rd(8'h02, 32'h6);
      wr(8'h02, 32'h0);
      rd(8'h02, 32'h6);
      wr(8'h02, 32'h6);
      rd(8'h02, 32'h0);
      wr(8'h00, 32'h8);
      offer <= 1'b0;
      mem_wr_ready_in <= 1'b0;
    end
  endtask
  task t_to_drv;
    begin
      wr(8'h00, 32'h1);
      mem_go <= 1'b1;
      repeat (20) @(posedge clk_sys_in);
      #1 chk(ntx, 3, "ntx");
      chk(got, 2, "last");
      rd(8'h02, 32'h4);
      wr(8'h00, 32'h0);
      wr(8'h02, 32'h4);
      mem_go <= 1'b0;
    end
  endtask
  task t_abort;
    begin
      wr(8'h08, 32'h00030001);
      wr(8'h00, 32'h9);
      offer <= 1'b1;
      drive_ready_in <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
      rd(8'h02, 32'hB);
      wr(8'h00, 32'h8);
      #1 chk(mem_wr_valid_out, 0, "flush");
      chk(drv_rx_ready_out, 0, "rx_rdy");
      rd(8'h02, 32'hA);
      wr(8'h02, 32'hA);
      offer <= 1'b0;
      drive_ready_in <= 1'b1;
      drive_irq_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      rd(8'h02, 32'h4);
      drive_irq_in <= 1'b0;
    end
  endtask
  // Prints the verdict and ends the run.
  task test_done;
    begin
      if (errors == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_regs;
    t_to_mem;
    t_to_drv;
    t_abort;
    test_done;
  end
  // Cuts a hang short well past the expected run time.
  initial begin
    #20000;
    errors = errors + 1;
    test_done;
  end
endmodule
